// ===== design/clpu_top.sv
// Purpose: cold load pick-up detector with timers, events and operation log
// Assumes: currents and blocking input synchronous to mclk_in
// Notes: decisions run once per 5 ms program cycle
// Operation
// RULE1: blocking input sampled once per program cycle, used for that cycle.
// RULE2: pick-up without blocking asserts active output and starts timing.
// RULE3: pick-up with blocking asserts blocked output and goes no further.
// RULE4: blocking during active resets it like a normal release; the code moves to the blocked state and asserts the blocked output instead.
// RULE5: blocking issues a display pulse and a stamped event with currents, fault type; the code issues both only while storing of ON events is enabled.
// RULE6: software switch may drive blocking only with forcing mode enabled.
// RULE7: external blocking must arrive at least 5 ms before the delay expires.
// RULE8: low dwell setting in 5 ms steps, default 10 s.
// RULE9: inrush maximum setting in 5 ms steps, default 30 s.
// RULE10: minimum hold setting, default 40 ms, also the reclaim time.
// RULE11: current above low before dwell ends prevents activation.
// RULE12: zero dwell activates at once when currents go low.
// RULE13: high current starts inrush timer; return below high ends start-up.
// RULE14: active output outlasts start-up end while minimum hold is nonzero.
// RULE15: any phase above overcurrent releases active immediately.
// RULE16: high current until inrush maximum expires releases at expiry.
// RULE17: no inrush: active held for minimum hold then released.
// RULE18: inrush within minimum hold runs inrush timer; release as described.
// RULE19: ON and OFF events for six flags, software selects which are stored.
// RULE20: each stored event carries time stamp and process data; OFF events get the stamp only, as only ON events are logged.
// RULE21: rolling log of last 12 records, oldest overwritten.
// RULE22: record holds stamp, id, currents, timers, reclaim count, group.
// RULE23: low needs all phases, high needs all phases, overcurrent any phase.
// RULE24: comparators drop out at 97 % of setting.
// RULE25: eight setting groups, one selector, changeable while running.
// RULE26: timers count program ticks; reset clears timers, outputs, state.
`default_nettype none
`include "clpu_params.svh"
module clpu_top
  import clpu_pkg::*;
#(
  parameter int CYCLE_CLKS = `CLPU_CYCLE_CLKS,
  parameter int MS_CLKS = `CLPU_MS_CLKS
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // register port
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // measurement and blocking
  input wire logic [15:0] cur_l1_in,
  input wire logic [15:0] cur_l2_in,
  input wire logic [15:0] cur_l3_in,
  input wire logic blk_in,
  // outputs
  output logic cold_load_active_out,
  output logic blocked_out,
  output logic notify_out,
  // event stream
  output logic evt_valid_out,
  output logic [3:0] evt_id_out,
  output logic [31:0] evt_stamp_out
);
  localparam int CW = $clog2(CYCLE_CLKS);
  localparam int MW = $clog2(MS_CLKS);
  localparam int NS = `CLPU_GROUPS * `CLPU_NSET;
  localparam logic [3:0] ID_BLOCK_ON = 4'ha;

  logic [CW-1:0] cyc_cnt_reg;
  logic [MW-1:0] ms_cnt_reg;
  logic [31:0] stamp_reg;
  logic tick;
  logic step_reg;
  logic [3:0] ctrl_reg;
  logic [2:0] grp_reg;
  logic [3:0] log_sel_reg;
  logic [19:0] set_reg [NS];
  logic blk_eff;
  logic blk_reg;
  logic [15:0] cur [3];
  logic [2:0] above_low;
  logic [2:0] above_high;
  logic [2:0] above_over;
  logic all_low;
  logic all_high;
  logic any_over;
  clpu_state_e state_reg;
  logic [19:0] dwell_cnt_reg;
  logic [19:0] min_cnt_reg;
  logic [19:0] max_cnt_reg;
  logic [19:0] act_cnt_reg;
  logic pick;
  logic [5:0] flags;
  logic [5:0] flags_prev_reg;
  logic [11:0] pend_reg;
  logic [11:0] pend_set;
  logic [3:0] serve_id;
  logic serve;
  clpu_rec_s log_reg [`CLPU_LOG_DEPTH];
  logic [3:0] log_ptr_reg;
  logic [3:0] log_cnt_reg;
  clpu_rec_s rec;

  function automatic logic [5:0] sidx(input logic [2:0] g, input clpu_set_e p);
    sidx = 6'(g * `CLPU_NSET) + 6'(p);
  endfunction : sidx

  function automatic logic [19:0] set_default(input int p);
    case (p)
      0: set_default = `CLPU_DEF_LOW;
      1: set_default = `CLPU_DEF_HIGH;
      2: set_default = `CLPU_DEF_OVER;
      3: set_default = `CLPU_DEF_DWELL;
      4: set_default = `CLPU_DEF_MAX;
      default: set_default = `CLPU_DEF_MIN;
    endcase
  endfunction : set_default

  // active group view of the settings
  logic [19:0] s_low, s_high, s_over, s_dwell, s_max, s_min;
  assign s_low = set_reg[sidx(grp_reg, CLPU_SET_LOW)]; // see RULE25
  assign s_high = set_reg[sidx(grp_reg, CLPU_SET_HIGH)];
  assign s_over = set_reg[sidx(grp_reg, CLPU_SET_OVER)];
  assign s_dwell = set_reg[sidx(grp_reg, CLPU_SET_DWELL)]; // see RULE8
  assign s_max = set_reg[sidx(grp_reg, CLPU_SET_MAX)]; // see RULE9
  assign s_min = set_reg[sidx(grp_reg, CLPU_SET_MIN)]; // see RULE10

  // program tick and millisecond time stamp
  assign tick = (cyc_cnt_reg == CW'(CYCLE_CLKS - 1));
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cyc_cnt_reg <= '0;
      step_reg <= 1'b0;
    end else begin
      cyc_cnt_reg <= tick ? '0 : cyc_cnt_reg + CW'(1); // see RULE26
      step_reg <= tick;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ms_cnt_reg <= '0;
      stamp_reg <= 32'h0;
    end else if (ms_cnt_reg == MW'(MS_CLKS - 1)) begin
      ms_cnt_reg <= '0;
      stamp_reg <= stamp_reg + 32'h1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + MW'(1);
    end
  end

  // blocking: test switch only counts with forcing enabled
  assign blk_eff = blk_in | (ctrl_reg[`CLPU_CTRL_FORCE_EN] & ctrl_reg[`CLPU_CTRL_FORCE_BLK]); // see RULE6
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      blk_reg <= 1'b0;
    end else if (tick) begin
      blk_reg <= blk_eff; // see RULE1 and RULE7
    end
  end

  // per-phase comparators
  assign cur[0] = cur_l1_in;
  assign cur[1] = cur_l2_in;
  assign cur[2] = cur_l3_in;
  for (genvar p = 0; p < 3; p++) begin : g_phase
    clpu_cmp #(.W(16)) u_low (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick),
      .value_in(cur[p]), .setting_in(s_low[15:0]), .above_out(above_low[p]));
    clpu_cmp #(.W(16)) u_high (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick),
      .value_in(cur[p]), .setting_in(s_high[15:0]), .above_out(above_high[p]));
    clpu_cmp #(.W(16)) u_over (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick),
      .value_in(cur[p]), .setting_in(s_over[15:0]), .above_out(above_over[p]));
  end
  assign all_low = ~|above_low; // see RULE23
  assign all_high = &above_high;
  assign any_over = |above_over;

  // pick-up: low condition held for the dwell time, zero dwell is immediate
  assign pick = step_reg && all_low &&
    ((state_reg == CLPU_ST_NORMAL && s_dwell == 20'h0) || // see RULE12
     (state_reg == CLPU_ST_DWELL && (dwell_cnt_reg + 20'h1) >= s_dwell));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= CLPU_ST_NORMAL; // see RULE26
      dwell_cnt_reg <= 20'h0;
      min_cnt_reg <= 20'h0;
      max_cnt_reg <= 20'h0;
      act_cnt_reg <= 20'h0;
    end else if (pick) begin
      state_reg <= blk_reg ? CLPU_ST_BLOCKED : CLPU_ST_ACTIVE; // see RULE2 and RULE3
      min_cnt_reg <= 20'h0;
      max_cnt_reg <= 20'h0;
      act_cnt_reg <= 20'h0;
    end else if (step_reg) begin
      case (state_reg)
        CLPU_ST_NORMAL: begin
          if (all_low) begin
            state_reg <= CLPU_ST_DWELL;
            dwell_cnt_reg <= 20'h0;
          end
        end
        CLPU_ST_DWELL: begin
          if (!all_low) begin
            state_reg <= CLPU_ST_NORMAL; // see RULE11
          end else begin
            dwell_cnt_reg <= dwell_cnt_reg + 20'h1;
          end
        end
        CLPU_ST_ACTIVE: begin
          act_cnt_reg <= act_cnt_reg + 20'h1;
          if (min_cnt_reg < s_min) begin
            min_cnt_reg <= min_cnt_reg + 20'h1;
          end
          if (blk_reg) begin
            state_reg <= CLPU_ST_BLOCKED; // see RULE4
          end else if (any_over) begin
            state_reg <= CLPU_ST_REARM; // see RULE15
          end else if (all_high) begin
            max_cnt_reg <= max_cnt_reg + 20'h1; // see RULE13 and RULE18
            if ((max_cnt_reg + 20'h1) >= s_max) begin
              state_reg <= CLPU_ST_REARM; // see RULE16
            end
          end else if ((min_cnt_reg + 20'h1) >= s_min) begin
            // start-up over or never began: hold only for the minimum time
            state_reg <= CLPU_ST_REARM; // see RULE14 and RULE17
          end
        end
        CLPU_ST_BLOCKED: begin
          if (!blk_reg) begin
            state_reg <= CLPU_ST_REARM;
          end
        end
        CLPU_ST_REARM: begin
          // wait for load to return so a released pick-up does not re-arm at once
          if (!all_low) begin
            state_reg <= CLPU_ST_NORMAL;
          end
        end
        default: state_reg <= CLPU_ST_NORMAL;
      endcase
    end
  end

  assign cold_load_active_out = (state_reg == CLPU_ST_ACTIVE);
  assign blocked_out = (state_reg == CLPU_ST_BLOCKED);

  // event flags: low, high, normal, over, activated, blocked
  assign flags = {blocked_out, cold_load_active_out, any_over,
    ~all_low & ~all_high & ~any_over, all_high, all_low};
  for (genvar i = 0; i < 6; i++) begin : g_evt
    assign pend_set[2*i] = flags[i] & ~flags_prev_reg[i] & ctrl_reg[`CLPU_CTRL_STORE_ON]; // see RULE19
    assign pend_set[2*i+1] = ~flags[i] & flags_prev_reg[i] & ctrl_reg[`CLPU_CTRL_STORE_OFF];
  end

  always_comb begin
    serve = 1'b0;
    serve_id = 4'h0;
    for (int k = 11; k >= 0; k--) begin
      if (pend_reg[k]) begin
        serve = 1'b1;
        serve_id = 4'(k);
      end
    end
  end

  // one event leaves per cycle; a new edge wins over the serve clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // comparators idle low after reset, so the low flag starts set: no false edge
      flags_prev_reg <= 6'h01;
      pend_reg <= 12'h0;
    end else begin
      flags_prev_reg <= flags;
      pend_reg <= (pend_reg & ~(12'(serve) << serve_id)) | pend_set;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      evt_valid_out <= 1'b0;
      evt_id_out <= 4'h0;
      evt_stamp_out <= 32'h0;
      notify_out <= 1'b0;
    end else begin
      evt_valid_out <= serve;
      evt_id_out <= serve_id;
      evt_stamp_out <= stamp_reg; // see RULE20
      notify_out <= serve && serve_id == ID_BLOCK_ON; // see RULE5
    end
  end

  // snapshot of process data for the log
  always_comb begin
    rec.stamp = stamp_reg;
    rec.id = serve_id;
    rec.cur_l1 = cur_l1_in;
    rec.cur_l2 = cur_l2_in;
    rec.cur_l3 = cur_l3_in;
    rec.to_act = (state_reg == CLPU_ST_DWELL) ? s_dwell - dwell_cnt_reg : 20'h0;
    rec.act_time = act_cnt_reg;
    rec.start_time = max_cnt_reg;
    rec.reclaim = min_cnt_reg;
    rec.fault = above_over | above_high; // see RULE5
    rec.group = grp_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      log_ptr_reg <= 4'h0;
      log_cnt_reg <= 4'h0;
    end else if (serve && !serve_id[0]) begin
      log_reg[log_ptr_reg] <= rec; // see RULE22
      log_ptr_reg <= (log_ptr_reg == 4'(`CLPU_LOG_DEPTH - 1)) ? 4'h0 : log_ptr_reg + 4'h1; // see RULE21
      if (log_cnt_reg != 4'(`CLPU_LOG_DEPTH)) begin
        log_cnt_reg <= log_cnt_reg + 4'h1;
      end
    end
  end

  // register writes
  logic set_hit;
  logic [2:0] set_par;
  assign set_hit = reg_addr_in[9:8] == 2'(`CLPU_A_SET_BASE >> 8);
  assign set_par = reg_addr_in[4:2];
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_reg <= `CLPU_CTRL_RESET;
      grp_reg <= 3'h0;
      log_sel_reg <= 4'h0;
      for (int g = 0; g < NS; g++) begin
        set_reg[g] <= set_default(g % `CLPU_NSET);
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == `CLPU_A_CTRL) begin
        ctrl_reg <= reg_wdata_in[3:0];
      end else if (reg_addr_in == `CLPU_A_GROUP) begin
        grp_reg <= reg_wdata_in[2:0];
      end else if (reg_addr_in == `CLPU_A_LOGSEL) begin
        log_sel_reg <= reg_wdata_in[3:0];
      end else if (set_hit && set_par < 3'(`CLPU_NSET)) begin
        set_reg[sidx(reg_addr_in[7:5], clpu_set_e'(set_par))] <= reg_wdata_in[19:0];
      end
    end
  end

  // register reads, data in the following cycle
  clpu_rec_s lr;
  logic [31:0] rd_val;
  logic [9:0] log_off;
  assign lr = log_reg[(log_sel_reg < 4'(`CLPU_LOG_DEPTH)) ? log_sel_reg : 4'h0];
  assign log_off = reg_addr_in - `CLPU_A_LOG_BASE;
  always_comb begin
    rd_val = 32'h0;
    if (reg_addr_in == `CLPU_A_CTRL) begin
      rd_val = {28'h0, ctrl_reg};
    end else if (reg_addr_in == `CLPU_A_GROUP) begin
      rd_val = {29'h0, grp_reg};
    end else if (reg_addr_in == `CLPU_A_STATUS) begin
      rd_val = {20'h0, blk_reg, state_reg, 2'h0, flags};
    end else if (reg_addr_in == `CLPU_A_STAMP) begin
      rd_val = stamp_reg;
    end else if (reg_addr_in == `CLPU_A_LOGSEL) begin
      rd_val = {28'h0, log_sel_reg};
    end else if (reg_addr_in == `CLPU_A_LOGPTR) begin
      rd_val = {24'h0, log_cnt_reg, log_ptr_reg};
    end else if (set_hit && set_par < 3'(`CLPU_NSET)) begin
      rd_val = {12'h0, set_reg[sidx(reg_addr_in[7:5], clpu_set_e'(set_par))]};
    end else if (reg_addr_in >= `CLPU_A_LOG_BASE && log_off[1:0] == 2'h0 &&
                 log_off[9:2] < 8'(`CLPU_LOG_FIELDS)) begin
      case (log_off[5:2])
        4'h0: rd_val = lr.stamp;
        4'h1: rd_val = {28'h0, lr.id};
        4'h2: rd_val = {16'h0, lr.cur_l1};
        4'h3: rd_val = {16'h0, lr.cur_l2};
        4'h4: rd_val = {16'h0, lr.cur_l3};
        4'h5: rd_val = {12'h0, lr.to_act};
        4'h6: rd_val = {12'h0, lr.act_time};
        4'h7: rd_val = {12'h0, lr.start_time};
        4'h8: rd_val = {12'h0, lr.reclaim};
        default: rd_val = {26'h0, lr.fault, lr.group};
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_val : 32'h0;
    end
  end

  // checks
  a_blk_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
    !$stable(blk_reg) |-> $past(tick)) else $error("blocking sampled off tick"); // see RULE1
  a_act_unblocked: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(cold_load_active_out) |-> !blk_reg) else $error("active under blocking"); // see RULE2
  a_blk_pickup: assert property (@(posedge mclk_in) disable iff (rst_in)
    pick && blk_reg |=> blocked_out && !cold_load_active_out) else $error("no blocked"); // see RULE3
  a_blk_release: assert property (@(posedge mclk_in) disable iff (rst_in)
    cold_load_active_out && step_reg && blk_reg |=> !cold_load_active_out && blocked_out)
    else $error("active kept under blocking"); // see RULE4
  a_notify_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
    serve && serve_id == ID_BLOCK_ON |=> notify_out ##1 !notify_out)
    else $error("no block notification"); // see RULE5
  a_force_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    tick && !ctrl_reg[`CLPU_CTRL_FORCE_EN] && !blk_in |=> !blk_reg)
    else $error("forcing leaked"); // see RULE6
  a_dwell_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    step_reg && state_reg == CLPU_ST_NORMAL && all_low && s_dwell == 20'h0 && !blk_reg
    |=> cold_load_active_out) else $error("zero dwell not immediate"); // see RULE12
  a_over_release: assert property (@(posedge mclk_in) disable iff (rst_in)
    cold_load_active_out && step_reg && any_over |=> !cold_load_active_out)
    else $error("overcurrent not released"); // see RULE15
  a_inrush_expire: assert property (@(posedge mclk_in) disable iff (rst_in)
    cold_load_active_out && step_reg && !blk_reg && !any_over && all_high &&
    max_cnt_reg + 20'h1 >= s_max |=> state_reg == CLPU_ST_REARM)
    else $error("inrush timer ignored"); // see RULE16
  a_log_wrap: assert property (@(posedge mclk_in) disable iff (rst_in)
    log_ptr_reg == 4'hb && serve && !serve_id[0] |=> log_ptr_reg == 4'h0)
    else $error("log pointer wrap"); // see RULE21
  c_activate: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(cold_load_active_out));
  c_blocked: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(blocked_out));
  c_log_full: cover property (@(posedge mclk_in) disable iff (rst_in)
    log_cnt_reg == 4'hc);
endmodule : clpu_top
`default_nettype wire

// ===== design/clpu_params.svh
// Purpose: constants of the cold load pick-up block: offsets, fields, resets, timing
// Assumes: 20 MHz mclk_in, settings in 5 ms program-cycle steps, currents in 0.01 x In
// Notes: definitions only
`ifndef CLPU_PARAMS_SVH
`define CLPU_PARAMS_SVH

// register offsets, byte addresses on a 10-bit bus
`define CLPU_A_CTRL 10'h000
`define CLPU_A_GROUP 10'h004
`define CLPU_A_STATUS 10'h008
`define CLPU_A_STAMP 10'h00c
`define CLPU_A_LOGSEL 10'h010
`define CLPU_A_LOGPTR 10'h014
`define CLPU_A_LOG_BASE 10'h020
`define CLPU_A_SET_BASE 10'h100
`define CLPU_LOG_FIELDS 10

// control fields
`define CLPU_CTRL_FORCE_EN 0
`define CLPU_CTRL_FORCE_BLK 1
`define CLPU_CTRL_STORE_ON 2
`define CLPU_CTRL_STORE_OFF 3
`define CLPU_CTRL_RESET 4'hc

// setting group layout and defaults
`define CLPU_GROUPS 8
`define CLPU_NSET 6
`define CLPU_DEF_LOW 20'h00014
`define CLPU_DEF_HIGH 20'h00078
`define CLPU_DEF_OVER 20'h000c8
`define CLPU_DEF_DWELL 20'h007d0
`define CLPU_DEF_MAX 20'h01770
`define CLPU_DEF_MIN 20'h00008

// hysteresis: comparator drops out at 97 % of the setting
`define CLPU_HYST_NUM 97
`define CLPU_HYST_DEN 100

// timing
`define CLPU_CLK_NS 50
`define CLPU_CYCLE_NS 5000000
`define CLPU_CYCLE_CLKS (`CLPU_CYCLE_NS / `CLPU_CLK_NS)
`define CLPU_MS_NS 1000000
`define CLPU_MS_CLKS (`CLPU_MS_NS / `CLPU_CLK_NS)
`define CLPU_LOG_DEPTH 12

`endif

// ===== design/clpu_pkg.sv
// Purpose: types shared by the cold load pick-up block
// Assumes: nothing beyond the params header
// Notes: log record packs one operation entry
`default_nettype none
package clpu_pkg;
  typedef enum logic [2:0] {
    CLPU_ST_NORMAL  = 3'b000,
    CLPU_ST_DWELL   = 3'b001,
    CLPU_ST_ACTIVE  = 3'b010,
    CLPU_ST_BLOCKED = 3'b011,
    CLPU_ST_REARM   = 3'b100
  } clpu_state_e;

  typedef enum logic [2:0] {
    CLPU_SET_LOW   = 3'h0,
    CLPU_SET_HIGH  = 3'h1,
    CLPU_SET_OVER  = 3'h2,
    CLPU_SET_DWELL = 3'h3,
    CLPU_SET_MAX   = 3'h4,
    CLPU_SET_MIN   = 3'h5
  } clpu_set_e;

  typedef struct packed {
    logic [31:0] stamp;
    logic [3:0] id;
    logic [15:0] cur_l1;
    logic [15:0] cur_l2;
    logic [15:0] cur_l3;
    logic [19:0] to_act;
    logic [19:0] act_time;
    logic [19:0] start_time;
    logic [19:0] reclaim;
    logic [2:0] fault;
    logic [2:0] group;
  } clpu_rec_s;
endpackage : clpu_pkg
`default_nettype wire

// ===== design/clpu_cmp.sv
// Purpose: one over-threshold comparator with drop-out hysteresis
// Assumes: value and setting in the same units, updated on the program tick
// Notes: picks up above the setting, drops below 97 % of it
`default_nettype none
`include "clpu_params.svh"
module clpu_cmp #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  // compare
  input wire logic [W-1:0] value_in,
  input wire logic [W-1:0] setting_in,
  output logic above_out
);
  logic [W+7:0] val_scaled;
  logic [W+7:0] set_scaled;

  assign val_scaled = (W+8)'(value_in) * (W+8)'(`CLPU_HYST_DEN);
  assign set_scaled = (W+8)'(setting_in) * (W+8)'(`CLPU_HYST_NUM);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      above_out <= 1'b0;
    end else if (tick_in) begin
      if (value_in > setting_in) begin
        above_out <= 1'b1;
      end else if (val_scaled < set_scaled) begin
        above_out <= 1'b0; // see RULE24
      end
    end
  end
endmodule : clpu_cmp
`default_nettype wire

// ===== dv/clpu_meas_model.sv
// Purpose: phase current front end and blocking source model
// Assumes: values change just after a rising edge of mclk_in
// Notes: levels only; the bench picks when they move
`default_nettype none
module clpu_meas_model (
  // clock
  input wire logic mclk_in,
  // measurement and blocking
  output logic [15:0] l1_out,
  output logic [15:0] l2_out,
  output logic [15:0] l3_out,
  output logic blk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    l1_out = 16'h0032;
    l2_out = 16'h0032;
    l3_out = 16'h0032;
    blk_out = 1'b0;
  end
  task automatic set_i(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge mclk_in);
    l1_out <= a;
    l2_out <= b;
    l3_out <= c;
  endtask : set_i
  // raised whole program cycles ahead of any timer end
  task automatic set_blk(input logic b);
    @(posedge mclk_in);
    blk_out <= b;
  endtask : set_blk
endmodule : clpu_meas_model
`default_nettype wire

// ===== dv/cold_load_pickup_logic_tb.sv
// Purpose: self-checking bench for the cold load pick-up block
// Assumes: short program cycle of 20 clocks, settings in ticks
// Notes: checks land 1 ns after a clock edge, never on a decision edge
`default_nettype none
`include "clpu_params.svh"
module cold_load_pickup_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 20;
  localparam logic [9:0] SB = `CLPU_A_SET_BASE;
  localparam logic [31:0] DFLT [6] = '{32'h14, 32'h78, 32'hc8, 32'h7d0, 32'h1770, 32'h8};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, ev_st, r;
  logic [15:0] l1, l2, l3;
  logic blk, act, blkd, notify, ev_v;
  logic [3:0] ev_id;
  logic [3:0] seen_id = 4'h0;
  logic [31:0] seen_st = 32'h0;
  int err_count = 0;
  int checks = 0;
  always #25 mclk_in = ~mclk_in;
  clpu_meas_model i_meas (.mclk_in(mclk_in), .l1_out(l1), .l2_out(l2), .l3_out(l3),
    .blk_out(blk));
  clpu_top #(.CYCLE_CLKS(CYC), .MS_CLKS(4)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .cur_l1_in(l1), .cur_l2_in(l2), .cur_l3_in(l3), .blk_in(blk),
    .cold_load_active_out(act), .blocked_out(blkd), .notify_out(notify),
    .evt_valid_out(ev_v), .evt_id_out(ev_id), .evt_stamp_out(ev_st));
  always @(posedge mclk_in) begin
    if (notify === 1'b1) seen_id <= (ev_v === 1'b1) ? ev_id : 4'hf;
    if (ev_v === 1'b1 && ev_id === 4'h2) seen_st <= ev_st;
  end
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chkr(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkr
  task automatic chkl(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkl
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    rd_reg(a, r);
    chkr(r, exp);
  endtask : rchk
  task automatic tk(input int n);
    repeat (n * CYC) @(posedge mclk_in);
    #1;
  endtask : tk
  task automatic cur(input logic [15:0] v);
    i_meas.set_i(v, v, v);
  endtask : cur
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    rchk(`CLPU_A_CTRL, 32'hc);
    for (int p = 0; p < 6; p++) rchk(SB + 10'(p * 4), DFLT[p]);
    rchk(SB + 10'h018, 32'h0);
    rchk(10'h3fc, 32'h0);
    wr_reg(SB + 10'h00c, 32'h4);
    cur(16'h000a);
    tk(2);
    cur(16'h0032);
    tk(8);
    chkl(act, 1'b0);
    cur(16'h000a);
    tk(2);
    chkl(act, 1'b0);
    tk(4);
    chkl(act, 1'b1);
    cur(16'h0032);
    tk(3);
    chkl(act, 1'b1);
    tk(8);
    chkl(act, 1'b0);
    wr_reg(SB + 10'h00c, 32'h0);
    cur(16'h000a);
    tk(2);
    chkl(act, 1'b1);
    i_meas.set_i(16'h00fa, 16'h000a, 16'h000a);
    tk(2);
    chkl(act, 1'b0);
    cur(16'h0032);
    tk(2);
    cur(16'h000a);
    tk(2);
    i_meas.set_blk(1'b1);
    tk(2);
    chkl(act, 1'b0);
    chkl(blkd, 1'b1);
    chkr({28'h0, seen_id}, 32'ha);
    rd_reg(`CLPU_A_STATUS, r);
    chkr({28'h0, r[11:8]}, 32'hb);
    i_meas.set_blk(1'b0);
    tk(2);
    chkl(blkd, 1'b0);
    cur(16'h0032);
    tk(12);
    wr_reg(`CLPU_A_CTRL, 32'hf);
    cur(16'h000a);
    tk(2);
    chkl(blkd, 1'b1);
    chkl(act, 1'b0);
    wr_reg(`CLPU_A_CTRL, 32'he);
    tk(2);
    chkl(blkd, 1'b0);
    cur(16'h0032);
    tk(12);
    wr_reg(SB + 10'h02c, 32'h0);
    wr_reg(SB + 10'h030, 32'h3);
    wr_reg(`CLPU_A_GROUP, 32'h1);
    cur(16'h000a);
    tk(2);
    chkl(act, 1'b1);
    cur(16'h0096);
    tk(1);
    chkl(act, 1'b1);
    tk(5);
    chkl(act, 1'b0);
    rd_reg(`CLPU_A_LOGPTR, r);
    chkr({28'h0, r[7:4]}, 32'hc);
    wr_reg(`CLPU_A_LOGSEL, (r[3:0] == 4'h0) ? 32'hb : {28'h0, r[3:0] - 4'h1});
    rchk(`CLPU_A_LOG_BASE + 10'h004, 32'h2);
    rchk(`CLPU_A_LOG_BASE + 10'h008, 32'h96);
    rchk(`CLPU_A_LOG_BASE + 10'h024, 32'h39);
    rchk(`CLPU_A_LOG_BASE, seen_st);
    cur(16'h0075);
    tk(2);
    rd_reg(`CLPU_A_STATUS, r);
    chkl(r[1], 1'b1);
    cur(16'h0074);
    tk(2);
    rd_reg(`CLPU_A_STATUS, r);
    chkl(r[1], 1'b0);
    summarize();
  end
endmodule : cold_load_pickup_logic_tb
`default_nettype wire
